// ### include/tag_buf_map.vh
// Register map, field positions and constants of the tag read/write buffer
`ifndef TAG_BUF_MAP_VH
`define TAG_BUF_MAP_VH

// ==========================================================================
// Buffer geometry
// ==========================================================================
`define BUF_DEPTH        3000
`define BUF_AW           12
`define BUS_AW           13
`define BUF_SEL_BIT      12

// ==========================================================================
// Register word addresses (buffer window when address bit 12 is set)
// ==========================================================================
`define REG_IRQ_EN       13'h0000
`define REG_IRQ_FLAG     13'h0001
`define REG_HOST_RESP    13'h0002
`define REG_STATUS       13'h0003
`define REG_FILE_ID      13'h0004
`define REG_FILE_OFFSET  13'h0005
`define REG_BLOCK_LEN    13'h0006
`define REG_BUF_START    13'h0007
`define REG_CUSTOM_SW    13'h0008

// ==========================================================================
// Field positions
// ==========================================================================
`define IRQ_GENERAL      0
`define IRQ_EXTRA        1
`define RESP_SERVICED    0
`define RESP_EXTRA_DONE  1
`define RESP_CUSTOM_SW   2
`define STAT_BUSY        2
`define STAT_PREFETCH    3

// ==========================================================================
// Values
// ==========================================================================
`define SW_DEFAULT       16'h9000
`define CMD_NONE         2'h0
`define CMD_READ         2'h1
`define CMD_UPDATE       2'h2

`endif

// ### verilog/byte_ram.v
// Byte-wide buffer memory with one write port and two read ports
`timescale 1ns/10ps
module byte_ram #(
	parameter DEPTH = 3000,
	parameter AW    = 12
) (
	input  wire          sys_clk,
	input  wire          wr_en,
	input  wire [15:0]   wr_addr,
	input  wire [7:0]    wr_data,
	input  wire [15:0]   rd_addr_a,
	output wire [7:0]    rd_data_a,
	input  wire [15:0]   rd_addr_b,
	output wire [7:0]    rd_data_b
);
	reg [7:0] mem [0:DEPTH-1];

	// Out-of-range indexes read zero and never write
	assign rd_data_a = (rd_addr_a < DEPTH) ? mem[rd_addr_a[AW-1:0]] : 8'h00;
	assign rd_data_b = (rd_addr_b < DEPTH) ? mem[rd_addr_b[AW-1:0]] : 8'h00;

	always @(posedge sys_clk) begin
		if (wr_en && wr_addr < DEPTH)
			mem[wr_addr[AW-1:0]] <= wr_data;
	end
endmodule // byte_ram

// ### verilog/irq_flags.v
// Sticky interrupt flags with enables and a combined host interrupt
`timescale 1ns/10ps
module irq_flags #(
	parameter N = 2
) (
	input  wire          sys_clk,
	input  wire          reset,
	input  wire [N-1:0]  irq_set,
	input  wire [N-1:0]  irq_clear,
	input  wire [N-1:0]  irq_enable,
	output reg  [N-1:0]  irq_flag,
	output reg           irq_out
);
	wire [N-1:0] next_flag;

	// A set in the clearing cycle wins
	assign next_flag = (irq_flag & ~irq_clear) | irq_set;

	always @(posedge sys_clk) begin
		if (reset) begin
			irq_flag <= {N{1'b0}};
			irq_out  <= 1'b0;
		end else begin
			irq_flag <= next_flag;
			irq_out  <= |(next_flag & irq_enable);
		end
	end
endmodule // irq_flags

// ### verilog/tag_read_prefetch_write_buffer.v
// Read prefetch and blocking write buffer engine with register slave
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
`include "tag_buf_map.vh"
module tag_read_prefetch_write_buffer #(
	parameter DEPTH = `BUF_DEPTH,
	parameter AW    = `BUF_AW
) (
	input  wire          sys_clk,
	input  wire          reset,
	input  wire [12:0]   avs_address,
	input  wire          avs_read,
	input  wire          avs_write,
	input  wire [31:0]   avs_writedata,
	input  wire [3:0]    avs_byteenable,
	output reg  [31:0]   avs_readdata,
	output reg           avs_waitrequest,
	input  wire          cmd_valid,
	output reg           cmd_ready,
	input  wire          cmd_update,
	input  wire [15:0]   cmd_file_id,
	input  wire [15:0]   cmd_offset,
	input  wire [15:0]   cmd_length,
	input  wire          rx_valid,
	input  wire [7:0]    rx_data,
	output reg           rx_ready,
	output reg           rsp_valid,
	output reg  [7:0]    rsp_data,
	output reg           rsp_last,
	input  wire          rsp_ready,
	output wire          host_irq
);
	// ==================================================================
	// Types and helpers
	// ==================================================================
	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_SHIFT = 3'd1;
	localparam [2:0] ST_RX    = 3'd2;
	localparam [2:0] ST_WAIT  = 3'd3;
	localparam [2:0] ST_TX    = 3'd4;
	localparam [31:0] DEPTH32 = DEPTH;
	localparam [16:0] DEPTH17 = DEPTH32[16:0];
	localparam [15:0] SW_DEF  = `SW_DEFAULT;

	// Valid length plus added bytes, held to the buffer size
	function [15:0] fill_sum;
		input [15:0] have;
		input [15:0] add;
		reg   [16:0] sum;
		begin
			sum = {1'b0, have} + {1'b0, add};
			if (sum > DEPTH17)
				fill_sum = DEPTH17[15:0];
			else
				fill_sum = sum[15:0];
		end
	endfunction

	// Byte-lane merge of a 16-bit register
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0]  be;
		begin
			merge16[7:0]  = be[0] ? wd[7:0] : old[7:0];
			merge16[15:8] = be[1] ? wd[15:8] : old[15:8];
		end
	endfunction

	// ==================================================================
	// State
	// ==================================================================
	reg  [2:0]   state;
	reg  [1:0]   cmd_code;
	reg  [1:0]   irq_en;
	reg  [1:0]   irq_set;
	reg          use_custom;
	reg  [15:0]  custom_sw;
	reg  [15:0]  file_id;
	reg  [15:0]  rep_off;
	reg  [15:0]  blk_len;
	reg  [15:0]  buf_start;
	reg  [15:0]  req_off;
	reg  [15:0]  req_len;
	reg  [15:0]  cache_off;
	reg  [15:0]  cache_len;
	reg          cache_valid;
	reg          pf_pending;
	reg  [15:0]  cp_src;
	reg  [15:0]  cp_dst;
	reg  [15:0]  cp_cnt;
	reg  [15:0]  tx_cnt;
	reg  [15:0]  tx_len;
	reg  [31:0]  rd_val;
	reg  [7:0]   tx_byte;
	wire [1:0]   irq_flag;
	wire [7:0]   ram_a;
	wire [7:0]   ram_b;

	// ==================================================================
	// Bus decode
	// ==================================================================
	wire        bus_wr    = avs_write && !avs_waitrequest;
	wire        sel_buf   = avs_address[`BUF_SEL_BIT];
	wire [15:0] bus_idx   = {4'h0, avs_address[11:0]};
	wire        bus_buf_wr = bus_wr && sel_buf && avs_byteenable[0]
		&& (state != ST_RX);
	wire        resp_wr   = bus_wr && avs_address == `REG_HOST_RESP
		&& avs_byteenable[0];
	wire        serviced  = resp_wr && avs_writedata[`RESP_SERVICED];
	wire        extra_done = resp_wr && avs_writedata[`RESP_EXTRA_DONE];
	wire [1:0]  flag_clr  = (bus_wr && avs_address == `REG_IRQ_FLAG
		&& avs_byteenable[0]) ? avs_writedata[1:0] : 2'b00;

	// ==================================================================
	// Cache hit check for an incoming read
	// ==================================================================
	wire [16:0] cache_end = {1'b0, cache_off} + {1'b0, cache_len};
	wire        in_range  = cache_valid && cmd_file_id == file_id
		&& cmd_offset >= cache_off && {1'b0, cmd_offset} < cache_end;
	wire [15:0] hit_start = cmd_offset - cache_off;
	wire [15:0] hit_avail = cache_len - hit_start;

	// ==================================================================
	// Buffer memory access
	// ==================================================================
	wire        shift_step = state == ST_SHIFT && cp_cnt != 16'h0000
		&& !bus_buf_wr;
	wire        rx_take    = state == ST_RX && rx_valid && rx_ready;
	wire        fsm_we     = shift_step || rx_take;
	wire [15:0] ram_rd_a   = (state == ST_SHIFT) ? cp_src : tx_cnt;

	byte_ram #(
		.DEPTH     (DEPTH),
		.AW        (AW)
	) u_ram (
		.sys_clk   (sys_clk),
		.wr_en     (fsm_we || bus_buf_wr),
		.wr_addr   (bus_buf_wr ? bus_idx : cp_dst),
		.wr_data   (bus_buf_wr ? avs_writedata[7:0] :
			(shift_step ? ram_a : rx_data)),
		.rd_addr_a (ram_rd_a),
		.rd_data_a (ram_a),
		.rd_addr_b (bus_idx),
		.rd_data_b (ram_b)
	);

	irq_flags #(
		.N          (2)
	) u_irq (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.irq_set    (irq_set),
		.irq_clear  (flag_clr),
		.irq_enable (irq_en),
		.irq_flag   (irq_flag),
		.irq_out    (host_irq)
	);

	// ==================================================================
	// Read data and response byte selection
	// ==================================================================
	always @* begin
		rd_val = 32'h0000_0000;
		if (sel_buf) begin
			rd_val[7:0] = ram_b;
		end else begin
			case (avs_address)
			`REG_IRQ_EN:      rd_val[1:0] = irq_en;
			`REG_IRQ_FLAG:    rd_val[1:0] = irq_flag;
			`REG_HOST_RESP:   rd_val[`RESP_CUSTOM_SW] = use_custom;
			`REG_STATUS:      rd_val[3:0] = {pf_pending,
				state != ST_IDLE, cmd_code};
			`REG_FILE_ID:     rd_val[15:0] = file_id;
			`REG_FILE_OFFSET: rd_val[15:0] = rep_off;
			`REG_BLOCK_LEN:   rd_val[15:0] = blk_len;
			`REG_BUF_START:   rd_val[15:0] = buf_start;
			`REG_CUSTOM_SW:   rd_val[15:0] = custom_sw;
			default:          rd_val = 32'h0000_0000;
			endcase
		end
	end

	always @* begin
		if (tx_cnt < tx_len)
			tx_byte = ram_a;
		else if (tx_cnt == tx_len)
			tx_byte = use_custom ? custom_sw[15:8] : SW_DEF[15:8];
		else
			tx_byte = use_custom ? custom_sw[7:0] : SW_DEF[7:0];
	end

	// ==================================================================
	// Bus slave handshake: one wait cycle, then answer
	// ==================================================================
	always @(posedge sys_clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rd_val : 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// ==================================================================
	// Registers and command engine
	// ==================================================================
	always @(posedge sys_clk) begin
		if (reset) begin
			state       <= ST_IDLE;
			cmd_code    <= `CMD_NONE;
			irq_en      <= 2'b00;
			irq_set     <= 2'b00;
			use_custom  <= 1'b0;
			custom_sw   <= 16'h0000;
			file_id     <= 16'h0000;
			rep_off     <= 16'h0000;
			blk_len     <= 16'h0000;
			buf_start   <= 16'h0000;
			req_off     <= 16'h0000;
			req_len     <= 16'h0000;
			cache_off   <= 16'h0000;
			cache_len   <= 16'h0000;
			cache_valid <= 1'b0;
			pf_pending  <= 1'b0;
			cp_src      <= 16'h0000;
			cp_dst      <= 16'h0000;
			cp_cnt      <= 16'h0000;
			tx_cnt      <= 16'h0000;
			tx_len      <= 16'h0000;
			cmd_ready   <= 1'b0;
			rx_ready    <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_data    <= 8'h00;
			rsp_last    <= 1'b0;
		end else begin
			irq_set <= 2'b00;
			if (state == ST_IDLE)
				cmd_ready <= 1'b1;

			// Host writes
			if (bus_wr && avs_address == `REG_IRQ_EN && avs_byteenable[0])
				irq_en <= avs_writedata[1:0];
			if (bus_wr && avs_address == `REG_BLOCK_LEN)
				blk_len <= merge16(blk_len, avs_writedata, avs_byteenable);
			if (bus_wr && avs_address == `REG_CUSTOM_SW)
				custom_sw <= merge16(custom_sw, avs_writedata,
					avs_byteenable);
			if (resp_wr && avs_writedata[`RESP_CUSTOM_SW])
				use_custom <= 1'b1;

			// Extra data delivered: grow the valid region
			if (extra_done && pf_pending) begin
				cache_len  <= fill_sum(cache_len, blk_len);
				pf_pending <= 1'b0;
			end

			case (state)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					cmd_ready  <= 1'b0;
					req_off    <= cmd_offset;
					req_len    <= cmd_length;
					file_id    <= cmd_file_id;
					pf_pending <= 1'b0;
					cp_dst     <= 16'h0000;
					if (cmd_update) begin
						cmd_code    <= `CMD_UPDATE;
						cache_valid <= 1'b0;
						rx_ready    <= cmd_length != 16'h0000;
						state       <= ST_RX;
					end else begin
						cmd_code    <= `CMD_READ;
						cp_src      <= in_range ? hit_start : 16'h0000;
						cp_cnt      <= in_range ? hit_avail : 16'h0000;
						cache_len   <= in_range ? hit_avail : 16'h0000;
						cache_off   <= cmd_offset;
						cache_valid <= 1'b1;
						state       <= ST_SHIFT;
					end
				end
			end
			ST_SHIFT: begin
				if (cp_cnt != 16'h0000) begin
					if (shift_step) begin
						cp_src <= cp_src + 16'h0001;
						cp_dst <= cp_dst + 16'h0001;
						cp_cnt <= cp_cnt - 16'h0001;
					end
				end else if (cache_len >= req_len) begin
					tx_cnt <= 16'h0000;
					tx_len <= req_len;
					state  <= ST_TX;
					if (irq_en[`IRQ_EXTRA]) begin
						irq_set[`IRQ_EXTRA] <= 1'b1;
						pf_pending <= 1'b1;
						buf_start  <= cache_len;
					end
				end else begin
					buf_start <= cache_len;
					blk_len   <= req_len - cache_len;
					rep_off   <= req_off + cache_len;
					irq_set[`IRQ_GENERAL] <= 1'b1;
					state     <= ST_WAIT;
				end
			end
			ST_RX: begin
				if (rx_take) begin
					cp_dst <= cp_dst + 16'h0001;
					if (cp_dst + 16'h0001 >= req_len)
						rx_ready <= 1'b0;
				end else if (!rx_ready) begin
					buf_start <= 16'h0000;
					blk_len   <= req_len;
					rep_off   <= req_off;
					irq_set[`IRQ_GENERAL] <= 1'b1;
					state     <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (serviced) begin
					if (use_custom || cmd_code == `CMD_UPDATE) begin
						tx_cnt <= 16'h0000;
						tx_len <= 16'h0000;
						state  <= ST_TX;
						if (use_custom)
							cache_valid <= 1'b0;
					end else begin
						cache_len <= fill_sum(cache_len, blk_len);
						state     <= ST_SHIFT;
					end
				end
			end
			ST_TX: begin
				if (!rsp_valid || rsp_ready) begin
					if (tx_cnt == tx_len + 16'h0002) begin
						rsp_valid  <= 1'b0;
						rsp_last   <= 1'b0;
						use_custom <= 1'b0;
						state      <= ST_IDLE;
					end else begin
						rsp_valid <= 1'b1;
						rsp_data  <= tx_byte;
						rsp_last  <= tx_cnt == tx_len + 16'h0001;
						tx_cnt    <= tx_cnt + 16'h0001;
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // tag_read_prefetch_write_buffer

// ### verif/tag_buf_monitor.sv
// Checker for bus, stream and interrupt timing of the buffer engine
`timescale 1ns/10ps
module tag_buf_monitor (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic        rx_ready,
	input wire logic        rsp_valid,
	input wire logic [7:0]  rsp_data,
	input wire logic        rsp_last,
	input wire logic        rsp_ready,
	input wire logic        host_irq
);
	// ======================================================================
	// Properties
	// ======================================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_bus_one_wait: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer did not come after one wait");
	a_bus_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_cmd_taken_once: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("command ready stayed high after a take");
	a_rsp_hold_byte: assert property (rsp_valid && !rsp_ready |=>
		rsp_valid && $stable(rsp_data) && $stable(rsp_last))
		else $error("response byte changed while stalled");
	a_rsp_last_ends: assert property (rsp_valid && rsp_ready && rsp_last
		|=> !rsp_valid)
		else $error("response went on after its last byte");
	a_rx_when_busy: assert property (rx_ready |-> !cmd_ready)
		else $error("payload accepted while idle");
	a_rsp_when_busy: assert property (rsp_valid |-> !cmd_ready)
		else $error("response sent while idle");
	a_irq_rise_busy: assert property ($rose(host_irq) |-> !cmd_ready)
		else $error("interrupt rose with no command in hand");
endmodule // tag_buf_monitor

bind tag_read_prefetch_write_buffer tag_buf_monitor tag_buf_monitor_inst (
	.sys_clk, .reset, .avs_read, .avs_write, .avs_waitrequest, .cmd_valid,
	.cmd_ready, .rx_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_ready,
	.host_irq
);

// ### verif/reader_model.sv
// Reader-side model: issues commands, streams payload, collects replies
`timescale 1ns/10ps
module reader_model (
	input  wire logic        sys_clk,
	output logic             cmd_valid,
	output logic             cmd_update,
	output logic [15:0]      cmd_file_id,
	output logic [15:0]      cmd_offset,
	output logic [15:0]      cmd_length,
	input  wire logic        cmd_ready,
	output logic             rx_valid,
	output logic [7:0]       rx_data,
	input  wire logic        rx_ready,
	input  wire logic        rsp_valid,
	input  wire logic [7:0]  rsp_data,
	input  wire logic        rsp_last,
	output logic             rsp_ready
);
	logic [7:0] pl[$];
	logic [8:0] q[$];

	initial begin
		cmd_valid = 0;
		cmd_update = 0;
		cmd_file_id = 0;
		cmd_offset = 0;
		cmd_length = 0;
		rx_valid = 0;
		rx_data = 0;
		rsp_ready = 0;
	end

	// ======================================================================
	// Command issue, held until taken
	// ======================================================================
	task automatic issue(input logic u, input logic [15:0] f, o, n);
		cmd_update <= u;
		cmd_file_id <= f;
		cmd_offset <= o;
		cmd_length <= n;
		cmd_valid <= 1;
		@(posedge sys_clk);
		while (!cmd_ready) @(posedge sys_clk);
		cmd_valid <= 0;
		cmd_file_id <= ~f;
		cmd_offset <= ~o;
		cmd_length <= ~n;
	endtask

	// ======================================================================
	// Payload out, response in with a stall on every other cycle
	// ======================================================================
	always @(posedge sys_clk) begin
		rsp_ready <= ~rsp_ready;
		if (rsp_valid && rsp_ready)
			q.push_back({rsp_last, rsp_data});
		if (rx_valid && rx_ready) begin
			rx_valid <= 0;
			rx_data <= ~rx_data;
		end else if (!rx_valid && pl.size() > 0) begin
			rx_valid <= 1;
			rx_data <= pl.pop_front();
		end
	end
endmodule // reader_model

// ### verif/tag_read_prefetch_write_buffer_bench.sv
// Self-checking bench: host register flows against the reader model
`timescale 1ns/10ps
`include "tag_buf_map.vh"
module tag_read_prefetch_write_buffer_bench;
	localparam logic [31:0] m16 = 32'h0000_ffff;
	logic        sys_clk = 0;
	logic        reset = 1;
	logic [12:0] avs_address = 0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, cmd_valid, cmd_ready, cmd_update;
	logic [15:0] cmd_file_id, cmd_offset, cmd_length;
	logic        rx_valid, rx_ready, rsp_valid, rsp_last, rsp_ready;
	logic [7:0]  rx_data, rsp_data;
	logic        host_irq;
	int          error_cnt = 0;
	int          samples_checked = 0;

	always #5 sys_clk = ~sys_clk;

	tag_read_prefetch_write_buffer tag_read_prefetch_write_buffer_inst (
		.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
		.avs_waitrequest, .cmd_valid, .cmd_ready, .cmd_update, .cmd_file_id,
		.cmd_offset, .cmd_length, .rx_valid, .rx_data, .rx_ready,
		.rsp_valid, .rsp_data, .rsp_last, .rsp_ready, .host_irq
	);
	reader_model reader_model_inst (
		.sys_clk, .cmd_valid, .cmd_update, .cmd_file_id, .cmd_offset,
		.cmd_length, .cmd_ready, .rx_valid, .rx_data, .rx_ready,
		.rsp_valid, .rsp_data, .rsp_last, .rsp_ready
	);

	// ======================================================================
	// Tasks
	// ======================================================================
	task automatic finish_test;
		if (error_cnt == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [12:0] a,
		input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		@(posedge sys_clk);
		while (avs_waitrequest) @(posedge sys_clk);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask

	task automatic rchk(input logic [12:0] a, input logic [31:0] m, e);
		logic [31:0] q;
		bus(0, a, 0, q);
		chk($sformatf("reg %h", a), e, q & m);
	endtask

	task automatic fill(input int bs, input int off, input int n);
		for (int i = 0; i < n; i++)
			wr(13'h1000 + 13'(bs + i), 32'(off + i + 16));
	endtask

	task automatic wirq;
		for (int i = 0; i < 300 && host_irq !== 1'b1; i++)
			@(posedge sys_clk);
		chk("host_irq", 1, 32'(host_irq));
	endtask

	task automatic rsp(input logic [7:0] x, input logic l);
		for (int i = 0; i < 300 && reader_model_inst.q.size() == 0; i++)
			@(posedge sys_clk);
		chk("rsp byte", {l, x}, reader_model_inst.q.size() ?
			reader_model_inst.q.pop_front() : 'x);
	endtask

	task automatic rdat(input int off, input int n);
		for (int i = 0; i < n; i++)
			rsp(8'(off + i + 16), 0);
		rsp(8'h90, 0);
		rsp(8'h00, 1);
	endtask

	task automatic svc_gen;
		wr(`REG_IRQ_FLAG, 1);
		wr(`REG_HOST_RESP, 1);
	endtask

	task automatic svc_ext(input int n);
		wr(`REG_BLOCK_LEN, 32'(n));
		wr(`REG_IRQ_FLAG, 2);
		wr(`REG_HOST_RESP, 2);
	endtask

	// ======================================================================
	// Tests
	// ======================================================================
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		finish_test;
	end

	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 0;
		@(posedge sys_clk);
		rchk(`REG_IRQ_EN, 3, 0);
		rchk(13'h00f0, 32'hffff_ffff, 0);
		wr(`REG_IRQ_EN, 3);
		// Miss, then prefetch append
		reader_model_inst.issue(0, 1, 0, 4);
		wirq;
		rchk(`REG_STATUS, 3, 1);
		rchk(`REG_BUF_START, m16, 0);
		rchk(`REG_BLOCK_LEN, m16, 4);
		fill(0, 0, 4);
		svc_gen;
		rdat(0, 4);
		rchk(`REG_IRQ_FLAG, 3, 2);
		chk("host_irq", 1, 32'(host_irq));
		rchk(`REG_BUF_START, m16, 4);
		fill(4, 4, 4);
		svc_ext(4);
		chk("host_irq", 0, 32'(host_irq));
		// Hit served from the buffer
		reader_model_inst.issue(0, 1, 4, 4);
		rdat(4, 4);
		rchk(`REG_IRQ_FLAG, 3, 2);
		rchk(`REG_BUF_START, m16, 4);
		fill(4, 8, 2);
		svc_ext(2);
		// Partial hit asks only for the rest
		reader_model_inst.issue(0, 1, 8, 4);
		wirq;
		rchk(`REG_BUF_START, m16, 2);
		rchk(`REG_FILE_OFFSET, m16, 10);
		rchk(`REG_BLOCK_LEN, m16, 2);
		fill(2, 10, 2);
		svc_gen;
		rdat(8, 4);
		svc_ext(0);
		// Other file, custom status word
		reader_model_inst.issue(0, 2, 0, 2);
		wirq;
		rchk(`REG_FILE_ID, m16, 2);
		wr(`REG_CUSTOM_SW, 32'h0000_6a82);
		wr(`REG_HOST_RESP, 4);
		wr(`REG_IRQ_FLAG, 1);
		wr(`REG_HOST_RESP, 5);
		rsp(8'h6a, 0);
		rsp(8'h82, 1);
		wr(`REG_IRQ_FLAG, 3);
		chk("host_irq", 0, 32'(host_irq));
		// Two blocking updates through the same buffer region
		wr(`REG_IRQ_EN, 1);
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 3 - k; i++)
				reader_model_inst.pl.push_back(8'(8'ha0 + 16 * k + i));
			reader_model_inst.issue(1, 3, 16'(32 + k), 16'(3 - k));
			wirq;
			rchk(`REG_STATUS, 3, 2);
			rchk(`REG_FILE_ID, m16, 3);
			rchk(`REG_BUF_START, m16, 0);
			rchk(`REG_BLOCK_LEN, m16, 32'(3 - k));
			for (int i = 0; i < 3 - k; i++)
				rchk(13'h1000 + 13'(i), 255, 32'(8'ha0 + 16 * k + i));
			svc_gen;
			rsp(8'h90, 0);
			rsp(8'h00, 1);
		end
		wr(`REG_FILE_ID, 32'h0000_0055);
		rchk(`REG_FILE_ID, m16, 3);
		finish_test;
	end
endmodule // tag_read_prefetch_write_buffer_bench
